//--- logic/dancer_consts.vh
// Constants for the dancer position loop: register map, reset values, codes and timing
`ifndef DANCER_CONSTS_VH
`define DANCER_CONSTS_VH

// Register byte offsets
`define OFS_ACTION    8'h00
`define OFS_SETPOINT  8'h04
`define OFS_UPPER     8'h08
`define OFS_LOWER     8'h0c
`define OFS_RANGE     8'h10
`define OFS_INFUNC0   8'h14
`define OFS_INFUNC1   8'h18
`define OFS_OUTFUNC   8'h1c
`define OFS_ACCEL2    8'h20
`define OFS_DECEL2    8'h24
`define OFS_THERM     8'h28
`define OFS_MAINSRC   8'h2c
`define OFS_BIAS      8'h30
`define OFS_GAIN      8'h34
`define OFS_NETBITS   8'h38
`define OFS_STATUS    8'h3c
`define OFS_MEAS      8'h40
`define OFS_FREQ      8'h44

// Reset values
`define RST_ACTION    8'h00
`define RST_NOVALUE   16'h270f
`define RST_RANGE     2'h0
`define RST_INFUNC    40'h00_0000_0000
`define RST_OUTFUNC   24'h00_0000
`define RST_RAMP      16'h0032
`define RST_MAINSRC   2'h0
`define RST_BIAS      16'h0000
`define RST_GAIN      16'h1770
`define RST_NETBITS   5'h00

// Parameter codes
`define ACT_LO        8'h28
`define ACT_HI        8'h2b
`define IN_LOOP_EN    8'h0e
`define OUT_LOWER     8'h0e
`define OUT_UPPER     8'h0f
`define OUT_DIR       8'h10
`define OUT_ACTIVE    8'h2f
`define OUT_NEG       8'h64
`define SRC_T2        2'h0
`define SRC_T4        2'h1
`define SRC_DIG       2'h2

// Percent scale in 0.1 % steps
`define PCT_FULL      11'h3e8
`define PCT_HALF      11'h1f4
`define ADC_4MA       12'h333
`define K_RANGE0      15'h4e25
`define K_RANGE1      15'h7d00
`define K_RANGE2      15'h3e84
`define RECIP_K       12'h419

// Ramp timing: one tick every 10 us, ramp times in 0.1 s over the full 60.00 Hz span
`define CLK_MHZ       125
`define TICK_US       10
`define TICK_CYCLES   (`TICK_US * `CLK_MHZ)
`define TICKS_PER_UNIT 14'h2710
`define RAMP_SPAN     31'h0000_1770

`endif

//--- logic/dancer_position_loop.v
// Dancer roller position loop with APB register access and routed output flags
`timescale 1ns/1ps
`include "dancer_consts.vh"

module dancer_position_loop (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [4:0]  input_terminals,
  input  wire [11:0] terminal4_code,
  input  wire [15:0] terminal2_freq,
  input  wire [15:0] terminal4_freq,
  input  wire [15:0] digital_freq,
  input  wire        forward_run,
  input  wire        reverse_run,
  output reg  [15:0] freq_command,
  output reg  [2:0]  output_terminals,
  output reg         loop_active
);

  reg [7:0]  loop_action_select;
  reg [15:0] setpoint_param;
  reg [15:0] upper_limit_param;
  reg [15:0] lower_limit_param;
  reg [1:0]  analog_range_select;
  reg [39:0] input_function_select;
  reg [23:0] output_function_select;
  reg [15:0] second_accel_time;
  reg [15:0] second_decel_time;
  reg [15:0] thermistor_protection_level;
  reg [1:0]  main_source_select;
  reg [15:0] terminal2_bias_frequency;
  reg [15:0] terminal2_gain_frequency;
  reg [4:0]  network_terminal_bits;

  reg [4:0]  term_meta;
  reg [4:0]  term_sync;
  reg [10:0] meas_pct;
  reg        upper_limit_flag;
  reg        lower_limit_flag;
  reg        rotation_direction_flag;
  reg        main_refused;
  reg [15:0] main_ramp;
  reg [30:0] ramp_acc;
  reg [10:0] tick_cnt;
  reg        tick;

  // Shown in STATUS and MEAS, so declared ahead of the read mux
  wire        dancer_sel;
  wire [10:0] sp_pct;

  // APB slave: zero wait states, read data captured in the setup cycle
  // Read data comes from setup, so a STATUS read shows state one cycle before the access
  // Writes to read-only or unmapped offsets fall to the default branch and change nothing
  wire wr_en = psel & penable & pwrite;
  wire rd_setup = psel & ~penable;
  reg  [31:0] next_prdata;
  reg         next_pslverr;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_action_select          <= `RST_ACTION;
      setpoint_param              <= `RST_NOVALUE;
      upper_limit_param           <= `RST_NOVALUE;
      lower_limit_param           <= `RST_NOVALUE;
      analog_range_select         <= `RST_RANGE;
      input_function_select       <= `RST_INFUNC;
      output_function_select      <= `RST_OUTFUNC;
      second_accel_time           <= `RST_RAMP;
      second_decel_time           <= `RST_RAMP;
      thermistor_protection_level <= `RST_NOVALUE;
      main_source_select          <= `RST_MAINSRC;
      terminal2_bias_frequency    <= `RST_BIAS;
      terminal2_gain_frequency    <= `RST_GAIN;
      network_terminal_bits       <= `RST_NETBITS;
    end else if (wr_en) begin
      case (paddr)
        `OFS_ACTION:   loop_action_select <= pwdata[7:0];
        `OFS_SETPOINT: setpoint_param <= pwdata[15:0];
        `OFS_UPPER:    upper_limit_param <= pwdata[15:0];
        `OFS_LOWER:    lower_limit_param <= pwdata[15:0];
        `OFS_RANGE:    analog_range_select <= pwdata[1:0];
        `OFS_INFUNC0:  input_function_select[31:0] <= pwdata;
        `OFS_INFUNC1:  input_function_select[39:32] <= pwdata[7:0];
        `OFS_OUTFUNC:  output_function_select <= pwdata[23:0];
        `OFS_ACCEL2:   second_accel_time <= pwdata[15:0];
        `OFS_DECEL2:   second_decel_time <= pwdata[15:0];
        `OFS_THERM:    thermistor_protection_level <= pwdata[15:0];
        `OFS_MAINSRC:  main_source_select <= pwdata[1:0];
        `OFS_BIAS:     terminal2_bias_frequency <= pwdata[15:0];
        `OFS_GAIN:     terminal2_gain_frequency <= pwdata[15:0];
        `OFS_NETBITS:  network_terminal_bits <= pwdata[4:0];
        default: begin
        end
      endcase
    end
  end

  always @* begin
    next_pslverr = 1'b0;
    case (paddr)
      `OFS_ACTION:   next_prdata = {24'h00_0000, loop_action_select};
      `OFS_SETPOINT: next_prdata = {16'h0000, setpoint_param};
      `OFS_UPPER:    next_prdata = {16'h0000, upper_limit_param};
      `OFS_LOWER:    next_prdata = {16'h0000, lower_limit_param};
      `OFS_RANGE:    next_prdata = {30'h0000_0000, analog_range_select};
      `OFS_INFUNC0:  next_prdata = input_function_select[31:0];
      `OFS_INFUNC1:  next_prdata = {24'h00_0000, input_function_select[39:32]};
      `OFS_OUTFUNC:  next_prdata = {8'h00, output_function_select};
      `OFS_ACCEL2:   next_prdata = {16'h0000, second_accel_time};
      `OFS_DECEL2:   next_prdata = {16'h0000, second_decel_time};
      `OFS_THERM:    next_prdata = {16'h0000, thermistor_protection_level};
      `OFS_MAINSRC:  next_prdata = {30'h0000_0000, main_source_select};
      `OFS_BIAS:     next_prdata = {16'h0000, terminal2_bias_frequency};
      `OFS_GAIN:     next_prdata = {16'h0000, terminal2_gain_frequency};
      `OFS_NETBITS:  next_prdata = {27'h000_0000, network_terminal_bits};
      `OFS_STATUS:   next_prdata = {26'h000_0000, main_refused, loop_active, rotation_direction_flag,
                                    lower_limit_flag, upper_limit_flag, dancer_sel};
      `OFS_MEAS:     next_prdata = {5'h00, sp_pct, 5'h00, meas_pct};
      `OFS_FREQ:     next_prdata = {16'h0000, freq_command};
      default: begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (rd_setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_pslverr;
      end
    end
  end

  // Terminals come from the field wiring, so they are synchronised before use
  // Only the second flop feeds logic; the first may still be settling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_meta <= 5'h00;
      term_sync <= 5'h00;
    end else begin
      term_meta <= input_terminals;
      term_sync <= term_meta;
    end
  end

  // Loop enable mapping; a network bit drives the same enable as its terminal
  // The two are ORed, so either source alone can enable the loop
  reg     en_mapped;
  reg     en_level;
  integer i;
  always @* begin
    en_mapped = 1'b0;
    en_level  = 1'b0;
    for (i = 0; i < 5; i = i + 1) begin
      if (input_function_select[i*8 +: 8] == `IN_LOOP_EN) begin
        en_mapped = 1'b1;
        if (term_sync[i] | network_terminal_bits[i])
          en_level = 1'b1;
      end
    end
  end

  assign dancer_sel = (loop_action_select >= `ACT_LO) && (loop_action_select <= `ACT_HI);
  wire dancer_en  = dancer_sel && (!en_mapped || en_level);
  wire ratio_mode = loop_action_select[1];
  wire fwd_action = loop_action_select[0];

  // Terminal 4 scaling: offset in range 0 only, then fixed-point reciprocal, clipped at full scale
  // Reciprocal constants are rounded, so a result can be one step off; the clip caps full scale
  reg [11:0] adc_off;
  reg [14:0] adc_k;
  always @* begin
    case (analog_range_select)
      2'h0: begin
        adc_off = (terminal4_code > `ADC_4MA) ? (terminal4_code - `ADC_4MA) : 12'h000;
        adc_k   = `K_RANGE0;
      end
      2'h1: begin
        adc_off = terminal4_code;
        adc_k   = `K_RANGE1;
      end
      default: begin
        adc_off = terminal4_code;
        adc_k   = `K_RANGE2;
      end
    endcase
  end
  wire [26:0] adc_prod = adc_off * adc_k;
  wire [10:0] adc_pct  = adc_prod[26:16];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      meas_pct <= 11'h000;
    else
      meas_pct <= (adc_pct > `PCT_FULL) ? `PCT_FULL : adc_pct;
  end

  // Set point and limits in 0.1 % steps; 9999 is the no-value code
  assign sp_pct = (setpoint_param == `RST_NOVALUE) ? `PCT_HALF :
                  (setpoint_param > {5'h00, `PCT_FULL}) ? `PCT_FULL : setpoint_param[10:0];
  // Limit flags are gated by the selection alone, not by the loop enable input
  wire up_on = dancer_sel && (upper_limit_param != `RST_NOVALUE) &&
               ({5'h00, meas_pct} > upper_limit_param);
  wire lo_on = dancer_sel && (lower_limit_param != `RST_NOVALUE) &&
               ({5'h00, meas_pct} < lower_limit_param);

  // Main speed source; terminal 4 while the loop is selected and a thermistor-bound terminal 2 read as zero
  // A refused source reads zero rather than the measurement it carries
  reg [15:0] main_raw;
  reg        refused;
  always @* begin
    refused = 1'b0;
    case (main_source_select)
      `SRC_T2: begin
        refused  = (thermistor_protection_level != `RST_NOVALUE);
        main_raw = refused ? 16'h0000 : terminal2_freq;
      end
      `SRC_T4: begin
        refused  = dancer_sel;
        main_raw = refused ? 16'h0000 : terminal4_freq;
      end
      default: main_raw = digital_freq;
    endcase
  end

  // Ramp tick divider
  // A 10 us tick keeps the ramp accumulator narrow, at the price of a coarse first step
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 11'h000;
      tick     <= 1'b0;
    end else if (tick_cnt == `TICK_CYCLES - 1) begin
      tick_cnt <= 11'h000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 11'h001;
      tick     <= 1'b0;
    end
  end

  // Ramp: error-accumulating stepper, one 0.01 Hz step at most per tick, or a direct jump at zero ramp time.
  // While the loop is off the ramp tracks the output, so enabling starts from it.
  // A new ramp time applies from the next step; the accumulated remainder is kept.
  wire        ramp_up    = main_raw > main_ramp;
  wire [15:0] ramp_time  = ramp_up ? second_accel_time : second_decel_time;
  wire [30:0] ramp_limit = ramp_time * `TICKS_PER_UNIT;
  wire [30:0] next_acc   = ramp_acc + `RAMP_SPAN;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_ramp <= 16'h0000;
      ramp_acc  <= 31'h0000_0000;
    end else if (!dancer_en) begin
      main_ramp <= freq_command;
      ramp_acc  <= 31'h0000_0000;
    end else if (main_raw == main_ramp) begin
      ramp_acc <= 31'h0000_0000;
    end else if (ramp_limit == 31'h0000_0000) begin
      main_ramp <= main_raw;
    end else if (tick) begin
      if (next_acc >= ramp_limit) begin
        main_ramp <= ramp_up ? main_ramp + 16'h0001 : main_ramp - 16'h0001;
        ramp_acc  <= next_acc - ramp_limit;
      end else begin
        ramp_acc <= next_acc;
      end
    end
  end

  // Correction: deviation times span, divided by 1000 via a reciprocal multiply
  // The arithmetic shift floors, so a negative correction can come out one step larger
  wire signed [11:0] dev = fwd_action ? ($signed({1'b0, meas_pct}) - $signed({1'b0, sp_pct}))
                                      : ($signed({1'b0, sp_pct}) - $signed({1'b0, meas_pct}));
  wire [15:0] m_clip = (main_ramp < terminal2_bias_frequency) ? terminal2_bias_frequency :
                       (main_ramp > terminal2_gain_frequency) ? terminal2_gain_frequency : main_ramp;
  wire signed [16:0] fixed_span = $signed({1'b0, terminal2_gain_frequency}) -
                                  $signed({1'b0, terminal2_bias_frequency});
  wire signed [16:0] ratio_span = $signed({1'b0, m_clip}) - $signed({1'b0, terminal2_bias_frequency});
  wire signed [16:0] factor     = ratio_mode ? ratio_span : fixed_span;
  wire signed [12:0] recip      = $signed({1'b0, `RECIP_K});
  wire signed [41:0] corr_prod  = dev * factor * recip;
  wire signed [17:0] corr       = corr_prod[37:20];
  wire signed [18:0] sum        = $signed({3'b000, main_ramp}) + corr;
  wire [15:0] sum_clip = sum[18] ? 16'h0000 : (sum[17:16] != 2'b00) ? 16'hffff : sum[15:0];

  // Output flags and routing; code 100 and above drives inverted
  // Unassigned codes drive low, or high when inverted
  reg [2:0] next_out;
  reg [7:0] fcode;
  reg [7:0] fbase;
  reg       flevel;
  integer   j;
  always @* begin
    next_out = 3'h0;
    fcode    = 8'h00;
    fbase    = 8'h00;
    flevel   = 1'b0;
    for (j = 0; j < 3; j = j + 1) begin
      fcode = output_function_select[j*8 +: 8];
      fbase = (fcode >= `OUT_NEG) ? fcode - `OUT_NEG : fcode;
      case (fbase)
        `OUT_UPPER:  flevel = upper_limit_flag;
        `OUT_LOWER:  flevel = lower_limit_flag;
        `OUT_DIR:    flevel = rotation_direction_flag;
        `OUT_ACTIVE: flevel = loop_active;
        default:     flevel = 1'b0;
      endcase
      next_out[j] = (fcode >= `OUT_NEG) ? ~flevel : flevel;
    end
  end

  // With the loop off the main source passes straight through, without the second ramp

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_command            <= 16'h0000;
      loop_active             <= 1'b0;
      upper_limit_flag        <= 1'b0;
      lower_limit_flag        <= 1'b0;
      rotation_direction_flag <= 1'b0;
      main_refused            <= 1'b0;
      output_terminals        <= 3'h0;
    end else begin
      freq_command            <= dancer_en ? sum_clip : main_raw;
      loop_active             <= dancer_en;
      upper_limit_flag        <= up_on;
      lower_limit_flag        <= lo_on;
      rotation_direction_flag <= forward_run & ~reverse_run;
      main_refused            <= refused;
      output_terminals        <= next_out;
    end
  end

endmodule

//--- test/dancer_checker_asserts.sv
// Port-level assertions for the dancer position loop
`timescale 1ns/1ps
`include "dancer_consts.vh"
module dancer_checker (
  input wire        pclk,
  input wire        presetn,
  input wire [7:0]  paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire [4:0]  input_terminals,
  input wire        forward_run,
  input wire        reverse_run,
  input wire [2:0]  output_terminals,
  input wire        loop_active
);
  // Shadows of the steering registers, taken from completed writes
  reg  [7:0]  act;
  reg  [39:0] infn;
  reg  [23:0] ofn;
  reg  [4:0]  net;
  wire        in_rng = act >= `ACT_LO && act <= `ACT_HI;
  wire [4:0]  map = {infn[39:32] == 8'h0e, infn[31:24] == 8'h0e, infn[23:16] == 8'h0e,
                     infn[15:8] == 8'h0e, infn[7:0] == 8'h0e};
  wire        mapped = |map;
  wire        en = |(map & (input_terminals | net));
  wire        dir = forward_run && !reverse_run;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act <= `RST_ACTION;
      infn <= `RST_INFUNC;
      ofn <= `RST_OUTFUNC;
      net <= `RST_NETBITS;
    end else if (psel && penable && pwrite && pready) begin
      case (paddr)
        `OFS_ACTION:  act <= pwdata[7:0];
        `OFS_INFUNC0: infn[31:0] <= pwdata;
        `OFS_INFUNC1: infn[39:32] <= pwdata[7:0];
        `OFS_OUTFUNC: ofn <= pwdata[23:0];
        `OFS_NETBITS: net <= pwdata[4:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Windows of two to four cycles cover the input sync and output registers
  property p_off; !in_rng && !$past(in_rng) |-> !loop_active; endproperty
  a_off: assert property (p_off) else $error("loop on outside selection");
  property p_free; in_rng && $past(in_rng) && !mapped && !$past(mapped) |-> loop_active; endproperty
  a_free: assert property (p_free) else $error("loop off without mapped enable");
  property p_gated; (in_rng && mapped && !en) [*4] |-> !loop_active; endproperty
  a_gated: assert property (p_gated) else $error("loop on with enable low");
  property p_on; (in_rng && mapped && en) [*4] |-> loop_active; endproperty
  a_on: assert property (p_on) else $error("loop off with enable high");
  property p_dir; (ofn[7:0] == `OUT_DIR && dir) [*3] |-> output_terminals[0]; endproperty
  a_dir: assert property (p_dir) else $error("direction output low in forward");
  property p_neg; (ofn[15:8] == `OUT_DIR + `OUT_NEG && !dir) [*3] |-> output_terminals[1]; endproperty
  a_neg: assert property (p_neg) else $error("negated direction output low");
  property p_act; (ofn[23:16] == `OUT_ACTIVE && loop_active) [*3] |-> output_terminals[2]; endproperty
  a_act: assert property (p_act) else $error("active output low while loop runs");
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_err; psel && !penable && paddr > `OFS_FREQ |=> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error on unmapped address");
  c_loop: cover property ($rose(loop_active));
  c_err: cover property (pslverr);
  c_neg: cover property (ofn[15:8] == 8'h74 && output_terminals[1]);
endmodule
bind dancer_position_loop dancer_checker dancer_checker_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .input_terminals(input_terminals), .forward_run(forward_run), .reverse_run(reverse_run),
  .output_terminals(output_terminals), .loop_active(loop_active));

//--- test/dancer_partner.sv
// Roller position detector model driving the terminal 4 code
`timescale 1ns/1ps
module dancer_partner (
  input  wire        pclk,
  input  wire [10:0] pos,
  input  wire [1:0]  scale,
  input  wire        slow,
  output reg  [11:0] code
);
  // Slow mode holds a new position back eight cycles, like a lagging sensor
  // Operator keeps suspension off and normal ramps at zero
  reg [11:0] tgt;
  reg [2:0]  lag = 3'h0;
  initial code = 12'h000;
  always @* begin
    case (scale)
      2'h0:    tgt = 12'(819 + pos * 3276 / 1000);
      2'h1:    tgt = 12'(pos * 2048 / 1000);
      default: tgt = 12'(pos * 4095 / 1000);
    endcase
  end
  always @(posedge pclk) begin
    lag <= (code == tgt) ? 3'h0 : lag + 3'h1;
    if (!slow || lag == 3'h7)
      code <= tgt;
  end
endmodule

//--- test/dancer_position_loop_tb.sv
// Self-checking bench for the dancer position loop
`timescale 1ns/1ps
`include "dancer_consts.vh"
module dancer_position_loop_tb;
  reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         forward_run = 1'b0, reverse_run = 1'b0, slow = 1'b0, err;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [4:0]  input_terminals = 5'h00;
  reg  [15:0] terminal2_freq = 16'h0, terminal4_freq = 16'h0, digital_freq = 16'h0;
  reg  [10:0] pos = 11'h0;
  reg  [1:0]  rng = 2'h0;
  wire [31:0] prdata;
  wire [15:0] freq_command;
  wire [11:0] terminal4_code;
  wire [2:0]  output_terminals;
  wire        pready, pslverr, loop_active;
  integer     n_errors = 0, compares = 0, cyc = 0, a, k, m, e;
  int         rst_val[$] = '{0, 9999, 9999, 9999, 0, 0, 0, 0, 50, 50, 9999, 0, 0, 6000, 0};
  dancer_position_loop dancer_position_loop_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_terminals(input_terminals), .terminal4_code(terminal4_code), .terminal2_freq(terminal2_freq),
    .terminal4_freq(terminal4_freq), .digital_freq(digital_freq), .forward_run(forward_run),
    .reverse_run(reverse_run), .freq_command(freq_command), .output_terminals(output_terminals),
    .loop_active(loop_active));
  dancer_partner dancer_partner_inst (.pclk(pclk), .pos(pos), .scale(rng), .slow(slow), .code(terminal4_code));
  always #4 pclk = ~pclk;
  function integer mexp(input integer c, input integer r);
    begin
      if (r == 0)
        mexp = (c < 819) ? 0 : (c - 819) * 1000 / 3276;
      else
        mexp = c * 1000 / ((r == 1) ? 2048 : 4095);
      if (mexp > 1000)
        mexp = 1000;
    end
  endfunction
  // Proportional term only, default set point 50 % and default terminal 2 span
  function integer fexp(input integer sel, input integer main, input integer meas);
    integer d;
    begin
      d = (sel == 40 || sel == 42) ? 500 - meas : meas - 500;
      fexp = main + d * ((sel < 42) ? 6000 : main) / 1000;
    end
  endfunction
  task apb(input [7:0] ad, input wr, input [31:0] wd);
    begin
      @(posedge pclk);
      paddr <= ad;
      pwrite <= wr;
      pwdata <= wd;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task cmp(input [8*8:1] nm, input [31:0] got, input [31:0] exp, input [31:0] tol);
    begin
      compares = compares + 1;
      if (((got + tol >= exp) && (got <= exp + tol)) !== 1'b1) begin
        n_errors = n_errors + 1;
        $display("FAIL %0s expected %0d seen %0d", nm, exp, got);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("Compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // Whole run needs a few hundred cycles
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  initial begin
    rd = $urandom(32'h0f618e58);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    for (k = 0; k < 15; k = k + 1) begin
      apb(8'(k * 4), 1'b0, 32'h0);
      cmp("reset", rd, rst_val[k], 0);
    end
    apb(8'h80, 1'b1, 32'hffff_ffff);
    cmp("slverr", {31'h0, err}, 1, 0);
    apb(8'h80, 1'b0, 32'h0);
    cmp("unmapped", rd, 0, 0);
    $display("test registers done");
    for (a = 0; a < 3; a = a + 1) begin
      rng <= a[1:0];
      apb(`OFS_RANGE, 1'b1, a);
      for (k = 0; k < 3; k = k + 1) begin
        pos <= (k == 0) ? 11'h0 : (k == 1) ? 11'h3e8 : 11'($urandom % 1001);
        repeat (5) @(posedge pclk);
        apb(`OFS_MEAS, 1'b0, 32'h0);
        cmp("meas", rd[10:0], mexp(terminal4_code, a), 2);
        cmp("setpoint", rd[26:16], 500, 0);
      end
    end
    $display("test scaling done");
    for (a = 38; a < 45; a = a + 1) begin
      apb(`OFS_ACTION, 1'b1, a);
      repeat (3) @(posedge pclk);
      cmp("active", loop_active, a >= 40 && a <= 43, 0);
    end
    apb(`OFS_ACTION, 1'b1, 32'h0);
    repeat (3) @(posedge pclk);
    cmp("active", loop_active, 0, 0);
    apb(`OFS_ACTION, 1'b1, 32'h29);
    apb(`OFS_INFUNC1, 1'b1, 32'h0e);
    for (k = 0; k < 4; k = k + 1) begin
      input_terminals <= {k == 1, 4'($urandom)};
      apb(`OFS_NETBITS, 1'b1, (k == 3) ? 32'h10 : 32'h0f);
      repeat (5) @(posedge pclk);
      cmp("enable", loop_active, k % 2, 0);
    end
    apb(`OFS_INFUNC1, 1'b1, 32'h0);
    apb(`OFS_NETBITS, 1'b1, 32'h0);
    $display("test enable done");
    apb(`OFS_UPPER, 1'b1, 32'h258);
    apb(`OFS_LOWER, 1'b1, 32'h190);
    for (k = 0; k < 6; k = k + 1) begin
      m = 300 + 200 * (k % 3);
      pos <= 11'(m);
      apb(`OFS_OUTFUNC, 1'b1, (k > 2) ? 32'h0093_7273 : 32'h002f_0e0f);
      repeat (5) @(posedge pclk);
      e = 4 + ((m < 400) ? 2 : 0) + ((m > 600) ? 1 : 0);
      if (k > 2)
        e = e ^ 7;
      cmp("flags", output_terminals, e, 0);
    end
    apb(`OFS_UPPER, 1'b1, 32'h270f);
    repeat (4) @(posedge pclk);
    cmp("nolimit", output_terminals, 3, 0);
    apb(`OFS_OUTFUNC, 1'b1, 32'h0010_7410);
    for (k = 0; k < 3; k = k + 1) begin
      forward_run <= (k == 0);
      reverse_run <= (k == 1);
      repeat (4) @(posedge pclk);
      cmp("dir", output_terminals, (k == 0) ? 5 : 2, 0);
    end
    $display("test flags done");
    apb(`OFS_ACCEL2, 1'b1, 32'h0);
    apb(`OFS_DECEL2, 1'b1, 32'h0);
    for (a = 40; a < 44; a = a + 1) begin
      m = 1000 + $urandom % 4000;
      terminal2_freq <= m[15:0];
      pos <= (a == 40 || a == 42) ? 11'h12c : 11'h2bc;
      apb(`OFS_ACTION, 1'b1, a);
      repeat (5) @(posedge pclk);
      cmp("freq", freq_command, fexp(a, m, mexp(terminal4_code, 2)), 4);
    end
    apb(`OFS_ACTION, 1'b1, 32'h0);
    repeat (3) @(posedge pclk);
    cmp("plain", freq_command, m, 0);
    pos <= 11'h1f4;
    terminal4_freq <= 16'h07d0;
    apb(`OFS_MAINSRC, 1'b1, 32'h1);
    apb(`OFS_ACTION, 1'b1, 32'h28);
    repeat (5) @(posedge pclk);
    cmp("refused", freq_command, fexp(40, 0, mexp(terminal4_code, 2)), 4);
    apb(`OFS_ACTION, 1'b1, 32'h0);
    apb(`OFS_MAINSRC, 1'b1, 32'h0);
    apb(`OFS_THERM, 1'b1, 32'h64);
    repeat (3) @(posedge pclk);
    cmp("therm", freq_command, 0, 0);
    apb(`OFS_THERM, 1'b1, 32'h270f);
    digital_freq <= 16'($urandom % 6000);
    apb(`OFS_MAINSRC, 1'b1, 32'h2);
    repeat (3) @(posedge pclk);
    cmp("digital", freq_command, digital_freq, 0);
    apb(`OFS_MAINSRC, 1'b1, 32'h0);
    terminal2_freq <= 16'h03e8;
    apb(`OFS_ACCEL2, 1'b1, 32'h32);
    apb(`OFS_DECEL2, 1'b1, 32'h32);
    slow <= 1'b1;
    pos <= 11'h258;
    repeat (12) @(posedge pclk);
    apb(`OFS_ACTION, 1'b1, 32'h29);
    repeat (3) @(posedge pclk);
    terminal2_freq <= 16'h1388;
    repeat (20) @(posedge pclk);
    cmp("ramp", freq_command, fexp(41, 1000, mexp(terminal4_code, 2)), 4);
    $display("test speed done");
    print_verdict;
  end
endmodule
